// ==== src/sar_adc_ctrl.sv ====
// Conversion control and parallel read port of a four-channel 12-bit SAR converter.
// Assumes host strobes and the conversion clock arrive asynchronously on pins, and that the
// capacitor-array comparator answers within one conversion-clock cycle on CMP_HIGH.
// Contract
// R1: A start is taken on the write strobe's falling edge with chip select low.
// R2: Conversion begins on the first conversion-clock rise after the write strobe falls.
// R3: One bit per conversion-clock cycle, MSB first, LSB decided in cycle twelve.
// R4: Sample-and-hold charges from the selected input during cycles thirteen to sixteen.
// R5: Busy goes low after a start and high as soon as conversion completes.
// R6: After busy rises the host reads the result with chip select and read low.
// R7: Data pins driven only while chip select and read are both low. DATA_OE follows the synchronised strobes, two system clocks late.
// R8: Channel bits latch on write rise and select the next conversion's input.
// R9: Channel low bit high at read rise puts the converter in power-down.
// R10: Host holds write low over one conversion-clock rise plus 25 ns.
// R11: Host write strobe width comes from a 6-bit count, at most 64 cycles.
// R12: Host writes to start, takes busy rise as interrupt, reads one result.
// R13: Host drives the channel bits from two of its own address lines.
// R14: Conversion clock 200 kHz to 3.2 MHz; throughput is one sixteenth of it.
// R15: Host may poll the conversion clock and write a known time after it falls.
// R16: Continuous conversion needs starts at a fixed period to avoid jitter.
// R17: Full rate needs one write low phase every sixteen conversion-clock cycles.
// R18: First conversion after start-up has no latched channel and is flagged dummy.
// R19: Completed result stays stable until the next conversion completes.
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module sar_adc_ctrl (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic CS_N,
  input wire logic CHAN_SEL_LO,
  input wire logic CHAN_SEL_HI,
  input wire logic CONV_CLK,
  input wire logic CMP_HIGH,
  output logic BUSY_N,
  output logic [11:0] DATA_OUT,
  output logic DATA_OE,
  output logic [11:0] TRIAL_CODE,
  output logic SAMPLE_EN,
  output logic [1:0] MUX_SEL,
  output logic POWER_DOWN,
  output logic RESULT_DUMMY
);

  sar_adc_pkg::pins_s pin_raw;
  sar_adc_pkg::pins_s pin_q;
  sar_adc_pkg::pins_s pin_rise;
  sar_adc_pkg::pins_s pin_fall;
  sar_adc_pkg::conv_state_e state_r, state_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  sar_adc_pkg::result_t work_r, work_nxt;
  sar_adc_pkg::result_t trial_r, trial_nxt;
  sar_adc_pkg::result_t result_r, result_nxt;
  logic busy_n_r, busy_n_nxt;
  logic [1:0] mux_r, mux_nxt;
  logic pd_r, pd_nxt;
  logic chan_valid_r, chan_valid_nxt;
  logic held_ok_r, held_ok_nxt;
  logic dummy_r, dummy_nxt;
  logic arm_in_sample_r, arm_in_sample_nxt;
  logic start;
  logic conv_rise;
  logic done;
  sar_adc_pkg::result_t decided;

  // Bit under trial in a given conversion cycle; cycle one is the MSB.
  function automatic sar_adc_pkg::result_t bit_mask(input logic [4:0] cyc);
    sar_adc_pkg::result_t m;
    m = 12'h800 >> (cyc - `ADC_FIRST_CYC);
    return m;
  endfunction

  // All pins but CMP_HIGH, the conversion clock among them, pass two flip-flops first.
  assign pin_raw = '{wr_n: WR_N, rd_n: RD_N, cs_n: CS_N, chan_sel_hi: CHAN_SEL_HI,
                     chan_sel_lo: CHAN_SEL_LO, conv_clk: CONV_CLK};

  pin_sync #(
    .W($bits(sar_adc_pkg::pins_s))
  ) u_pin_sync (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .D(pin_raw),
    .Q(pin_q),
    .RISE(pin_rise),
    .FALL(pin_fall)
  );

  // Events seen by the sequencer.
  assign start = pin_fall.wr_n & ~pin_q.cs_n & ((state_r == sar_adc_pkg::ST_IDLE) |
                 (state_r == sar_adc_pkg::ST_SAMPLE)); // R1
  assign conv_rise = pin_rise.conv_clk; // R14
  assign done = (state_r == sar_adc_pkg::ST_CONV) & conv_rise & (cyc_r == `ADC_LAST_BIT_CYC);
  assign decided = CMP_HIGH ? (work_r | bit_mask(cyc_r)) : work_r; // R3

  // Next-state logic of the conversion frame. A start in the sample phase arms the next frame,
  // but charging goes on until the conversion clock rises, since a full-rate host writes
  // during cycle sixteen and would otherwise lose part of the sample.
  always_comb begin
    state_nxt = state_r;
    cyc_nxt = cyc_r;
    work_nxt = work_r;
    trial_nxt = trial_r;
    result_nxt = result_r;
    busy_n_nxt = busy_n_r;
    held_ok_nxt = held_ok_r;
    dummy_nxt = dummy_r;
    arm_in_sample_nxt = arm_in_sample_r;
    pd_nxt = pd_r;
    case (state_r)
      sar_adc_pkg::ST_IDLE, sar_adc_pkg::ST_SAMPLE: begin
        if (start) begin
          state_nxt = sar_adc_pkg::ST_ARMED;
          busy_n_nxt = 1'b0; // R5
          pd_nxt = 1'b0;
          arm_in_sample_nxt = (state_r == sar_adc_pkg::ST_SAMPLE); // R4
        end else if (state_r == sar_adc_pkg::ST_SAMPLE && conv_rise) begin
          if (cyc_r == `ADC_FRAME_CYC) begin
            state_nxt = sar_adc_pkg::ST_IDLE;
            held_ok_nxt = chan_valid_r; // R18
          end else begin
            cyc_nxt = cyc_r + 5'd1;
          end
        end
      end
      sar_adc_pkg::ST_ARMED: begin
        if (conv_rise) begin
          state_nxt = sar_adc_pkg::ST_CONV; // R2
          cyc_nxt = `ADC_FIRST_CYC;
          work_nxt = `ADC_RESULT_RST;
          trial_nxt = bit_mask(`ADC_FIRST_CYC); // R3
          arm_in_sample_nxt = 1'b0;
          // A sample phase that ran into this frame still counts once a channel is latched.
          if (arm_in_sample_r) begin
            held_ok_nxt = chan_valid_r; // R18
          end
        end
      end
      sar_adc_pkg::ST_CONV: begin
        if (conv_rise) begin
          work_nxt = decided;
          cyc_nxt = cyc_r + 5'd1;
          if (done) begin
            state_nxt = sar_adc_pkg::ST_SAMPLE; // R4
            result_nxt = decided; // R19
            busy_n_nxt = 1'b1; // R5
            dummy_nxt = ~held_ok_r; // R18
            held_ok_nxt = 1'b0;
            trial_nxt = decided;
          end else begin
            trial_nxt = decided | bit_mask(cyc_r + 5'd1); // R3
          end
        end
      end
      default: begin
        state_nxt = sar_adc_pkg::ST_IDLE;
      end
    endcase
    // Read rise with the channel low bit set parks the converter.
    if (pin_rise.rd_n & ~pin_q.cs_n & pin_q.chan_sel_lo) begin
      pd_nxt = 1'b1; // R9
    end
  end

  // Channel latch on the write strobe's rising edge; it steers the next sample phase.
  always_comb begin
    mux_nxt = mux_r;
    chan_valid_nxt = chan_valid_r;
    if (pin_rise.wr_n & ~pin_q.cs_n) begin
      mux_nxt = {pin_q.chan_sel_hi, pin_q.chan_sel_lo}; // R8
      chan_valid_nxt = 1'b1;
    end
  end

  // Registers of the sequencer; reset leaves the first result flagged as dummy.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= sar_adc_pkg::ST_IDLE;
      cyc_r <= 5'd0;
      work_r <= `ADC_RESULT_RST;
      trial_r <= `ADC_RESULT_RST;
      result_r <= `ADC_RESULT_RST;
      busy_n_r <= 1'b1;
      held_ok_r <= 1'b0;
      dummy_r <= 1'b1;
      arm_in_sample_r <= 1'b0;
      pd_r <= 1'b0;
      mux_r <= `ADC_MUX_RST;
      chan_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
      work_r <= work_nxt;
      trial_r <= trial_nxt;
      result_r <= result_nxt;
      busy_n_r <= busy_n_nxt;
      held_ok_r <= held_ok_nxt;
      dummy_r <= dummy_nxt;
      arm_in_sample_r <= arm_in_sample_nxt;
      pd_r <= pd_nxt;
      mux_r <= mux_nxt;
      chan_valid_r <= chan_valid_nxt;
    end
  end

  // Outputs. The bus enable decodes the synchronised strobes, so a read with chip select high leaves
  // the data pins released, and the enable follows the pins two system clocks late.
  assign BUSY_N = busy_n_r;
  assign DATA_OUT = result_r;
  assign DATA_OE = ~pin_q.cs_n & ~pin_q.rd_n; // R7
  assign TRIAL_CODE = trial_r;
  assign SAMPLE_EN = ((state_r == sar_adc_pkg::ST_SAMPLE) |
                      ((state_r == sar_adc_pkg::ST_ARMED) & arm_in_sample_r)) & ~pd_r; // R4
  assign MUX_SEL = mux_r;
  assign POWER_DOWN = pd_r;
  assign RESULT_DUMMY = dummy_r;

  // Checks of the frame sequence, three of them built from the named steps.
  sequence s_armed_rise;
    (state_r == sar_adc_pkg::ST_ARMED) && conv_rise;
  endsequence

  sequence s_completion;
    done;
  endsequence

  a_start_busy_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
    start |=> !BUSY_N && (state_r == sar_adc_pkg::ST_ARMED))
    else $error("Busy did not fall after a start.");

  a_start_needs_cs: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R1
    (pin_fall.wr_n && pin_q.cs_n && state_r == sar_adc_pkg::ST_IDLE) |=>
      state_r == sar_adc_pkg::ST_IDLE)
    else $error("Start taken without chip select.");

  a_conv_entry_msb: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R2
    s_armed_rise |=> (state_r == sar_adc_pkg::ST_CONV) && (cyc_r == 5'd1) &&
      (TRIAL_CODE == 12'h800))
    else $error("Conversion did not start with the MSB trial.");

  a_bit_per_cycle: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
    ((state_r == sar_adc_pkg::ST_CONV) && conv_rise && !done) |=>
      (cyc_r == $past(cyc_r) + 5'd1) && (TRIAL_CODE[12 - cyc_r] == 1'b1))
    else $error("Trial bit did not advance by one.");

  a_done_busy_high: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
    s_completion |=> BUSY_N && (DATA_OUT == $past(decided)) && (cyc_r == 5'd13))
    else $error("Completion did not release busy with the result.");

  a_sample_window: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R4
    SAMPLE_EN |-> (cyc_r >= 5'd13) && (cyc_r <= 5'd16))
    else $error("Sample phase outside cycles thirteen to sixteen.");

  a_oe_decode: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R7
    DATA_OE |-> !$past(CS_N, 2) && !$past(RD_N, 2))
    else $error("Data bus enabled without both strobes low.");

  a_mux_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
    (pin_rise.wr_n && !pin_q.cs_n) |=>
      MUX_SEL == $past({pin_q.chan_sel_hi, pin_q.chan_sel_lo}))
    else $error("Channel not latched at write rise.");

  a_power_down: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R9
    (pin_rise.rd_n && !pin_q.cs_n && pin_q.chan_sel_lo) |=> POWER_DOWN && !SAMPLE_EN)
    else $error("Power-down not entered on read rise.");

  a_result_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R19
    !done |=> $stable(DATA_OUT))
    else $error("Result changed without a completion.");

  a_dummy_first: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R18
    (s_completion and (held_ok_r == 1'b0)) |=> RESULT_DUMMY)
    else $error("Result without a latched channel not flagged dummy.");

endmodule // sar_adc_ctrl

// ==== src/sar_adc_cfg.svh ====
// Constants for the parallel-host converter control block.
// Assumes inclusion by bare name from the design files only.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// Result width and the conversion frame, counted in conversion-clock cycles.
`define ADC_RES_BITS 12
`define ADC_LAST_BIT_CYC 5'd12
`define ADC_SAMPLE_FIRST_CYC 5'd13
`define ADC_FRAME_CYC 5'd16
`define ADC_FIRST_CYC 5'd1

// Reset values.
`define ADC_RESULT_RST 12'h000
`define ADC_MUX_RST 2'h0

// Accepted conversion-clock range and throughput per clock.
`define ADC_CONV_CLK_MIN_KHZ 200
`define ADC_CONV_CLK_MAX_KHZ 3200
`define ADC_CLKS_PER_SAMPLE 16

// System clock period and the busy response time after a start.
`define SYS_CLK_PERIOD_PS 5000
`define ADC_BUSY_DELAY_NS 20
`define ADC_BUSY_DELAY_CYC ((`ADC_BUSY_DELAY_NS * 1000) / `SYS_CLK_PERIOD_PS)

// Synchroniser depth for pin inputs.
`define PIN_SYNC_STAGES 2

`endif

// ==== src/sar_adc_pkg.sv ====
// Types shared by the converter control block and its pin synchroniser.
// Assumes nothing beyond a SystemVerilog compiler.
package sar_adc_pkg;

  // Pin inputs from the host side and the conversion clock, kept together.
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic cs_n;
    logic chan_sel_hi;
    logic chan_sel_lo;
    logic conv_clk;
  } pins_s;

  // Conversion control states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SAMPLE = 4'b1000
  } conv_state_e;

  typedef logic [11:0] result_t;

endpackage

// ==== src/pin_sync.sv ====
// Two-stage synchroniser with edge pulses for a group of pin inputs.
// Assumes the inputs are asynchronous to CLK_SYS; edges come from stages two and three only.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 6
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q,
  output logic [W-1:0] RISE,
  output logic [W-1:0] FALL
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Each bit gets its own chain; strobes idle high so the chain resets high.
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          s1_r[i] <= 1'b1;
          s2_r[i] <= 1'b1;
          s3_r[i] <= 1'b1;
        end else begin
          s1_r[i] <= D[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
        end
      end
      // The first stage is never looked at here, to keep metastability out of the edges.
      assign Q[i] = s2_r[i];
      assign RISE[i] = s2_r[i] & ~s3_r[i];
      assign FALL[i] = ~s2_r[i] & s3_r[i];
    end
  endgenerate

endmodule // pin_sync

// ==== tb/host_port_model.sv ====
// Host-side partner: conversion clock source and the asynchronous memory port strobes.
// Assumes the bench overlaps a start only with reads, and resolves the data bus it hands in.
`timescale 1ns/1ps
module host_port_model (
  input wire logic CLK_SYS,
  input wire logic [11:0] DATA_BUS,
  output logic WR_N,
  output logic RD_N,
  output logic CS_N,
  output logic CHAN_SEL_LO,
  output logic CHAN_SEL_HI,
  output logic CONV_CLK
);
  localparam int HALF_CYC = 32; // A 320 ns period, 3.125 MHz.
  localparam int STROBE_CNT = 40; // Memory cycles of 10 ns; fits a 6-bit field.
  logic [5:0] host_addr = 6'h00;
  logic clk_q = 1'b0;
  int cc_cnt = 0;

  // Byte addressing leaves no low two lines, so lines four and five carry the channel.
  assign CHAN_SEL_LO = host_addr[4];
  assign CHAN_SEL_HI = host_addr[5];
  assign CONV_CLK = clk_q;

  // Free-running conversion clock, stepped on the falling system edge.
  always @(negedge CLK_SYS) begin
    cc_cnt <= (cc_cnt == HALF_CYC - 1) ? 0 : cc_cnt + 1;
    if (cc_cnt == HALF_CYC - 1) begin
      clk_q <= ~clk_q;
    end
  end

  // Strobes idle high from time zero.
  initial begin
    WR_N = 1'b1;
    RD_N = 1'b1;
    CS_N = 1'b1;
  end

  // The strobe starts after a clock fall, so it spans one rise and starts keep a fixed phase.
  task automatic start(input logic sel, input logic [1:0] ch);
    start_after(1, sel, ch);
  endtask

  // Counts conversion-clock falls before the write, which paces starts at a fixed period.
  task automatic start_after(input int falls, input logic sel, input logic [1:0] ch);
    repeat (falls) @(negedge clk_q);
    @(negedge CLK_SYS);
    host_addr[5:4] = ch;
    CS_N = ~sel;
    WR_N = 1'b0;
    repeat (STROBE_CNT * 2) @(negedge CLK_SYS);
    WR_N = 1'b1;
    @(negedge CLK_SYS);
    CS_N = 1'b1;
  endtask

  // Lowers the read strobes and samples the bus once synchronised.
  task automatic read_on(input logic cs, input logic rd, input logic lo, output logic [11:0] d);
    @(negedge CLK_SYS);
    host_addr[4] = lo;
    CS_N = ~cs;
    RD_N = ~rd;
    repeat (4) @(negedge CLK_SYS);
    d = DATA_BUS;
  endtask

  // Read strobe rises first, while chip select is still low.
  task automatic read_off();
    RD_N = 1'b1;
    repeat (4) @(negedge CLK_SYS);
    CS_N = 1'b1;
    host_addr[4] = 1'b0;
  endtask
endmodule // host_port_model

// ==== tb/sar_adc_parallel_host_interface_test.sv ====
// Self-checking bench for the converter control block with a host partner model.
// Assumes the design files and the partner model are compiled first.
`timescale 1ns/1ps
module sar_adc_parallel_host_interface_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmp_high = 1'b0;
  logic wr_n, rd_n, cs_n, chan_lo, chan_hi, conv_clk;
  logic busy_n, data_oe, sample_en, power_down, result_dummy;
  logic [11:0] data_out, trial_code, data_bus;
  logic [11:0] held = 12'h000;
  logic [1:0] mux_sel;
  logic [11:0] vin_tab [4] = '{12'h5a3, 12'hc3e, 12'h001, 12'hfff};
  int err_total = 0;
  int compares = 0;
  int busy_rises = 0;
  int samp_rises = 0;

  always #2.5 clk_sys = ~clk_sys;

  // A released bus shows the inverse of the last word, so stale data never passes.
  assign data_bus = data_oe ? data_out : ~data_out;

  // Sample-and-hold and comparator of the analog side.
  always @(negedge clk_sys) begin
    if (sample_en === 1'b1) begin
      held <= vin_tab[mux_sel];
    end
    cmp_high <= (held >= trial_code);
  end

  // Counts conversion-clock rises seen while busy and while sampling.
  always @(posedge conv_clk) begin
    if (busy_n === 1'b0) begin
      busy_rises++;
    end
    if (sample_en === 1'b1) begin
      samp_rises++;
    end
  end

  sar_adc_ctrl dut_u (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .WR_N(wr_n), .RD_N(rd_n), .CS_N(cs_n),
    .CHAN_SEL_LO(chan_lo), .CHAN_SEL_HI(chan_hi), .CONV_CLK(conv_clk), .CMP_HIGH(cmp_high),
    .BUSY_N(busy_n), .DATA_OUT(data_out), .DATA_OE(data_oe), .TRIAL_CODE(trial_code),
    .SAMPLE_EN(sample_en), .MUX_SEL(mux_sel), .POWER_DOWN(power_down),
    .RESULT_DUMMY(result_dummy)
  );

  host_port_model host_u (
    .CLK_SYS(clk_sys), .DATA_BUS(data_bus), .WR_N(wr_n), .RD_N(rd_n), .CS_N(cs_n),
    .CHAN_SEL_LO(chan_lo), .CHAN_SEL_HI(chan_hi), .CONV_CLK(conv_clk)
  );

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Waits for busy to rise, then lets the four sample cycles run out with some margin.
  task automatic settle();
    int n;
    n = 0;
    while (busy_n !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (320) @(negedge clk_sys);
  endtask

  // One conversion; a retry start lands mid-conversion and must be ignored.
  task automatic convert(input logic [1:0] ch, input logic retry);
    busy_rises = 0;
    samp_rises = 0;
    host_u.start(1'b1, ch);
    check(busy_n, 1'b0);
    if (retry) begin
      host_u.start(1'b1, ch);
    end
    settle();
    check(busy_rises[11:0], 12'd13);
    check(samp_rises[11:0], 12'd4);
    check(mux_sel, ch);
  endtask

  task automatic fetch(input logic [11:0] want);
    logic [11:0] d;
    host_u.read_on(1'b1, 1'b1, 1'b0, d);
    check(data_oe, 1'b1);
    check(d, want);
    host_u.read_off();
    repeat (4) @(negedge clk_sys);
    check(data_oe, 1'b0);
    check(power_down, 1'b0);
  endtask

  task automatic t_first();
    convert(2'd1, 1'b0);
    check(result_dummy, 1'b1);
  endtask

  // The result comes from the channel latched one conversion earlier.
  task automatic t_result();
    convert(2'd2, 1'b0);
    check(result_dummy, 1'b0);
    fetch(vin_tab[1]);
    fetch(vin_tab[1]);
  endtask

  task automatic t_refuse();
    host_u.start(1'b0, 2'd0);
    repeat (200) @(negedge clk_sys);
    check(busy_n, 1'b1);
    convert(2'd3, 1'b1);
    fetch(vin_tab[2]);
  endtask

  // Data drive needs both strobes low; a high low-channel bit at read rise powers down.
  task automatic t_strobes();
    logic [11:0] d;
    for (int i = 0; i < 4; i++) begin
      host_u.read_on(i[0], i[1], 1'b0, d);
      check(data_oe, (i == 3));
      host_u.read_off();
    end
    host_u.read_on(1'b1, 1'b1, 1'b1, d);
    host_u.read_off();
    repeat (4) @(negedge clk_sys);
    check(power_down, 1'b1);
    convert(2'd0, 1'b0);
    fetch(vin_tab[3]);
  endtask

  // Full rate: the second write falls in cycle sixteen, so frames start sixteen clocks apart.
  // The first result is read in between, and the sample phase must still run four cycles.
  task automatic t_full_rate();
    busy_rises = 0;
    samp_rises = 0;
    host_u.start(1'b1, 2'd1);
    fork
      host_u.start_after(15, 1'b1, 2'd2);
      begin
        while (busy_n !== 1'b1) @(negedge clk_sys);
        fetch(vin_tab[0]);
      end
    join
    settle();
    check(busy_rises[11:0], 12'd26);
    check(samp_rises[11:0], 12'd8);
    check(result_dummy, 1'b0);
    fetch(vin_tab[1]);
  endtask

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    t_first();
    t_result();
    t_refuse();
    t_strobes();
    t_full_rate();
    test_done();
  end

  // Watchdog well beyond the six conversions and reads above.
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
endmodule // sar_adc_parallel_host_interface_test
